// >>> logic/acpc_consts.svh
`ifndef ACPC_CONSTS_SVH
`define ACPC_CONSTS_SVH
`define ACPC_OFS_MODE0      5'h00
`define ACPC_OFS_CHAN       5'h04
`define ACPC_OFS_PRIO       5'h08
`define ACPC_OFS_IRQ_STAT   5'h0C
`define ACPC_OFS_IRQ_MASK   5'h10
`define ACPC_BIT_START      0
`define ACPC_BIT_SCAN       1
`define ACPC_BIT_REF_ON     7
`define ACPC_BIT_IDLE_RUN   6
`define ACPC_BIT_SCAN_WIDE  5
`define ACPC_BIT_PDONE      7
`define ACPC_BIT_PBUSY      6
`define ACPC_BIT_PSTART     5
`define ACPC_BIT_NBUSY      6
`define ACPC_BIT_NDONE      7
`define ACPC_IRQ_NDONE      0
`define ACPC_IRQ_PDONE      1
`define ACPC_LAST_CHAN      4'hB
`define ACPC_REF_SETTLE_NS  3000
`define ACPC_CLK_NS         5
`define ACPC_REF_SETTLE_CYC ((`ACPC_REF_SETTLE_NS+`ACPC_CLK_NS-1)/`ACPC_CLK_NS)
`endif

// >>> logic/acpc_pkg.sv
package acpc_pkg;
    typedef enum logic [2:0] {
        ACPC_IDLE  = 3'b001,
        ACPC_NORM  = 3'b010,
        ACPC_PRIO  = 3'b100
    } acpc_state_e;

    typedef struct packed {
        acpc_state_e state;
        logic        ref_on;
        logic        idle_run;
        logic        scan_wide;
        logic [3:0]  chan;
        logic        scan;
        logic [3:0]  prio_chan;
        logic        prio_done;
        logic        norm_done;
        logic [3:0]  cur_chan;
        logic [3:0]  last_chan;
        logic [1:0]  irq_stat;
        logic [1:0]  irq_mask;
        logic        ack;
        logic [31:0] rdata;
        logic        conv_req;
        logic [3:0]  conv_chan;
        logic        prio_pend;
    } acpc_state_s;
endpackage

// >>> logic/acpc_top.sv
// Our own choices: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "acpc_consts.svh"
// Register front end and sequencer for the converter channel control.
// The analog core is outside: it takes conv_req and conv_chan and answers
// with a one-cycle conv_done pulse from the same clock domain.
module acpc_top (
    input  wire logic        clock,
    input  wire logic        rstn,
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        idle_mode,
    input  wire logic        conv_done,
    output logic             conv_req,
    output logic [3:0]       conv_chan,
    output logic             ref_voltage_on,
    output logic             conv_enable,
    output logic             irq
);
    acpc_pkg::acpc_state_s s_reg;
    acpc_pkg::acpc_state_s s_next;
    logic                  access;
    logic                  wr;
    logic                  rd;
    logic                  idle_ff1_reg;
    logic                  idle_ff2_reg;

    // First channel of a scan range for the selected grouping.
    function automatic logic [3:0] scan_base(input logic [3:0] code,
                                             input logic       wide);
        if (code[3])
            scan_base = 4'h8;
        else if (!wide && code[2])
            scan_base = 4'h4;
        else
            scan_base = 4'h0;
    endfunction

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            idle_ff1_reg <= 1'b0;
            idle_ff2_reg <= 1'b0;
        end else begin
            idle_ff1_reg <= idle_mode;
            idle_ff2_reg <= idle_ff1_reg;
        end
    end

    // One wait cycle per access; a write lands on the edge that ends it.
    assign access = (avs_read || avs_write) && !s_reg.ack;
    assign wr = avs_write && s_reg.ack;
    assign rd = avs_read && !s_reg.ack;
    assign avs_waitrequest = (avs_read || avs_write) && !s_reg.ack;
    assign avs_readdata = s_reg.rdata;
    assign conv_req = s_reg.conv_req;
    assign conv_chan = s_reg.conv_chan;
    assign ref_voltage_on = s_reg.ref_on;
    assign conv_enable = !idle_ff2_reg || s_reg.idle_run;
    assign irq = |(s_reg.irq_stat & s_reg.irq_mask);

    always_comb begin
        logic start_n;
        logic start_p;
        logic run;
        start_n = 1'b0;
        start_p = 1'b0;
        run = conv_enable;
        s_next = s_reg;
        s_next.ack = access;
        s_next.conv_req = 1'b0;
        if (rd) begin
            unique case (avs_address)
                `ACPC_OFS_MODE0: begin
                    s_next.rdata = 32'h0;
                    s_next.rdata[`ACPC_BIT_NDONE] = s_reg.norm_done;
                    s_next.rdata[`ACPC_BIT_NBUSY] =
                        (s_reg.state == acpc_pkg::ACPC_NORM);
                    s_next.rdata[`ACPC_BIT_SCAN] = s_reg.scan;
                    s_next.norm_done = 1'b0;
                end
                `ACPC_OFS_CHAN:
                    s_next.rdata = {24'h0, s_reg.ref_on, s_reg.idle_run,
                                    s_reg.scan_wide, 1'b0, s_reg.chan};
                `ACPC_OFS_PRIO: begin
                    s_next.rdata = {24'h0, s_reg.prio_done,
                        (s_reg.state == acpc_pkg::ACPC_PRIO) ||
                        s_reg.prio_pend, 2'b00, s_reg.prio_chan};
                    s_next.prio_done = 1'b0;
                end
                `ACPC_OFS_IRQ_STAT: s_next.rdata = {30'h0, s_reg.irq_stat};
                `ACPC_OFS_IRQ_MASK: s_next.rdata = {30'h0, s_reg.irq_mask};
                default: s_next.rdata = 32'h0;
            endcase
        end
        if (wr) begin
            unique case (avs_address)
                `ACPC_OFS_MODE0: begin
                    s_next.scan = avs_writedata[`ACPC_BIT_SCAN];
                    start_n = avs_writedata[`ACPC_BIT_START];
                end
                `ACPC_OFS_CHAN: begin
                    s_next.ref_on = avs_writedata[`ACPC_BIT_REF_ON];
                    s_next.idle_run = avs_writedata[`ACPC_BIT_IDLE_RUN];
                    s_next.scan_wide = avs_writedata[`ACPC_BIT_SCAN_WIDE];
                    s_next.chan = avs_writedata[3:0];
                end
                `ACPC_OFS_PRIO: begin
                    s_next.prio_chan = avs_writedata[3:0];
                    start_p = avs_writedata[`ACPC_BIT_PSTART];
                end
                `ACPC_OFS_IRQ_STAT:
                    s_next.irq_stat = s_reg.irq_stat & ~avs_writedata[1:0];
                `ACPC_OFS_IRQ_MASK: s_next.irq_mask = avs_writedata[1:0];
                default: ;
            endcase
        end
        if (start_p) begin
            s_next.prio_pend = 1'b1;
            s_next.prio_done = 1'b0;
        end
        unique case (s_reg.state)
            acpc_pkg::ACPC_IDLE: begin
                if (run && (s_reg.prio_pend || start_p)) begin
                    s_next.prio_pend = 1'b0;
                    s_next.state = acpc_pkg::ACPC_PRIO;
                    s_next.conv_req = 1'b1;
                    s_next.conv_chan = start_p ? avs_writedata[3:0]
                                               : s_reg.prio_chan;
                end else if (start_n) begin
                    s_next.state = acpc_pkg::ACPC_NORM;
                    s_next.norm_done = 1'b0;
                    if (s_next.scan) begin
                        s_next.cur_chan = scan_base(s_reg.chan,
                                                    s_reg.scan_wide);
                        s_next.last_chan = s_reg.chan;
                    end else begin
                        s_next.cur_chan = s_reg.chan;
                        s_next.last_chan = s_reg.chan;
                    end
                    s_next.conv_req = 1'b1;
                    s_next.conv_chan = s_next.cur_chan;
                end
            end
            acpc_pkg::ACPC_NORM: begin
                if (conv_done) begin
                    if (s_reg.cur_chan == s_reg.last_chan) begin
                        s_next.state = acpc_pkg::ACPC_IDLE;
                        s_next.norm_done = 1'b1;
                        s_next.irq_stat[`ACPC_IRQ_NDONE] = 1'b1;
                    end else if (run) begin
                        s_next.cur_chan = s_reg.cur_chan + 4'h1;
                        s_next.conv_req = 1'b1;
                        s_next.conv_chan = s_reg.cur_chan + 4'h1;
                    end else begin
                        s_next.cur_chan = s_reg.cur_chan + 4'h1;
                    end
                end else if (run && !s_reg.conv_req && s_reg.conv_chan
                             != s_reg.cur_chan) begin
                    s_next.conv_req = 1'b1;
                    s_next.conv_chan = s_reg.cur_chan;
                end
            end
            acpc_pkg::ACPC_PRIO: begin
                if (conv_done) begin
                    s_next.state = acpc_pkg::ACPC_IDLE;
                    s_next.prio_done = 1'b1;
                    s_next.irq_stat[`ACPC_IRQ_PDONE] = 1'b1;
                end
            end
            default: s_next.state = acpc_pkg::ACPC_IDLE;
        endcase
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            s_reg <= '{state: acpc_pkg::ACPC_IDLE, default: '0};
        end else begin
            s_reg <= s_next;
        end
    end

    // Each access is answered after exactly one wait cycle.
    a_ack_single: assert property (
        @(posedge clock) disable iff (!rstn)
        s_reg.ack
        |=> !s_reg.ack)
        else $error("acknowledge held for two cycles");

    a_ref_follows: assert property (
        @(posedge clock) disable iff (!rstn)
        (wr && avs_address == `ACPC_OFS_CHAN)
        |=> ref_voltage_on == $past(avs_writedata[`ACPC_BIT_REF_ON]))
        else $error("reference enable does not follow the register");

    a_ref_holds: assert property (
        @(posedge clock) disable iff (!rstn)
        !(wr && avs_address == `ACPC_OFS_CHAN)
        |=> $stable(ref_voltage_on))
        else $error("reference enable changed without a write");

    a_idle_gate: assert property (
        @(posedge clock) disable iff (!rstn)
        (idle_ff2_reg && !s_reg.idle_run)
        |-> !conv_enable)
        else $error("converter runs in idle with idle-run off");

    a_idle_stop: assert property (
        @(posedge clock) disable iff (!rstn)
        (s_reg.state == acpc_pkg::ACPC_NORM && !conv_enable)
        |=> !conv_req)
        else $error("scan requested a conversion while stopped");

    a_scan_upper: assert property (
        @(posedge clock) disable iff (!rstn)
        (conv_req && s_reg.state == acpc_pkg::ACPC_NORM &&
         $past(s_reg.state) == acpc_pkg::ACPC_IDLE &&
         s_reg.scan && s_reg.chan[3])
        |-> conv_chan == 4'h8)
        else $error("upper scan does not start at input eight");

    a_scan_narrow: assert property (
        @(posedge clock) disable iff (!rstn)
        (conv_req && s_reg.state == acpc_pkg::ACPC_NORM &&
         $past(s_reg.state) == acpc_pkg::ACPC_IDLE && s_reg.scan &&
         !s_reg.scan_wide && s_reg.chan[3:2] == 2'b01)
        |-> conv_chan == 4'h4)
        else $error("narrow scan does not start at input four");

    a_scan_wide: assert property (
        @(posedge clock) disable iff (!rstn)
        (conv_req && s_reg.state == acpc_pkg::ACPC_NORM &&
         $past(s_reg.state) == acpc_pkg::ACPC_IDLE && s_reg.scan &&
         s_reg.scan_wide && !s_reg.chan[3])
        |-> conv_chan == 4'h0)
        else $error("wide scan does not start at input zero");

    a_fixed_chan: assert property (
        @(posedge clock) disable iff (!rstn)
        (conv_req && s_reg.state == acpc_pkg::ACPC_NORM &&
         $past(s_reg.state) == acpc_pkg::ACPC_IDLE &&
         !s_reg.scan)
        |-> conv_chan == s_reg.chan)
        else $error("fixed mode converts the wrong input");

    a_pdone_set: assert property (
        @(posedge clock) disable iff (!rstn)
        (s_reg.state == acpc_pkg::ACPC_PRIO && conv_done)
        |=> s_reg.prio_done)
        else $error("priority done not set");

    a_pdone_start: assert property (
        @(posedge clock) disable iff (!rstn)
        (wr && avs_address == `ACPC_OFS_PRIO &&
         avs_writedata[`ACPC_BIT_PSTART] &&
         s_reg.state != acpc_pkg::ACPC_PRIO)
        |=> !s_reg.prio_done)
        else $error("priority done not cleared by a start");

    a_pdone_rdclr: assert property (
        @(posedge clock) disable iff (!rstn)
        (rd && avs_address == `ACPC_OFS_PRIO &&
         !conv_done)
        |=> !s_reg.prio_done)
        else $error("priority done not cleared by read");

    a_pbusy_done: assert property (
        @(posedge clock) disable iff (!rstn)
        (s_reg.state == acpc_pkg::ACPC_PRIO &&
         !$past(conv_done))
        |-> !s_reg.prio_done)
        else $error("busy and done together");

    a_pbusy_idle: assert property (
        @(posedge clock) disable iff (!rstn)
        (rd && avs_address == `ACPC_OFS_PRIO &&
         s_reg.state == acpc_pkg::ACPC_IDLE && !s_reg.prio_pend)
        |=> !avs_readdata[`ACPC_BIT_PBUSY])
        else $error("priority busy reads one while idle");

    a_pbusy_run: assert property (
        @(posedge clock) disable iff (!rstn)
        (rd && avs_address == `ACPC_OFS_PRIO &&
         s_reg.state == acpc_pkg::ACPC_PRIO)
        |=> avs_readdata[`ACPC_BIT_PBUSY])
        else $error("priority busy reads zero while running");

    a_pstart_go: assert property (
        @(posedge clock) disable iff (!rstn)
        (wr && avs_address == `ACPC_OFS_PRIO &&
         avs_writedata[`ACPC_BIT_PSTART] &&
         s_reg.state == acpc_pkg::ACPC_IDLE && conv_enable)
        |=> conv_req)
        else $error("priority start ignored");

    a_pstart_rd0: assert property (
        @(posedge clock) disable iff (!rstn)
        (rd && avs_address == `ACPC_OFS_PRIO)
        |=> !avs_readdata[`ACPC_BIT_PSTART])
        else $error("priority start bit reads one");

    a_prio_chan: assert property (
        @(posedge clock) disable iff (!rstn)
        (conv_req && s_reg.state == acpc_pkg::ACPC_PRIO)
        |-> conv_chan == s_reg.prio_chan)
        else $error("priority conversion on the wrong input");

    a_scan_mode: assert property (
        @(posedge clock) disable iff (!rstn)
        (wr && avs_address == `ACPC_OFS_MODE0)
        |=> s_reg.scan == $past(avs_writedata[`ACPC_BIT_SCAN]))
        else $error("scan bit does not follow the write");

    a_nstart_go: assert property (
        @(posedge clock) disable iff (!rstn)
        (wr && avs_address == `ACPC_OFS_MODE0 &&
         avs_writedata[`ACPC_BIT_START] &&
         s_reg.state == acpc_pkg::ACPC_IDLE && !s_reg.prio_pend)
        |=> conv_req)
        else $error("normal start ignored");

    a_nstart_rd0: assert property (
        @(posedge clock) disable iff (!rstn)
        (rd && avs_address == `ACPC_OFS_MODE0)
        |=> !avs_readdata[`ACPC_BIT_START])
        else $error("normal start bit reads one");

    a_scan_order: assert property (
        @(posedge clock) disable iff (!rstn)
        (conv_req && s_reg.state == acpc_pkg::ACPC_NORM &&
         $past(s_reg.state) == acpc_pkg::ACPC_NORM && $past(conv_done))
        |-> conv_chan == $past(conv_chan) + 4'h1)
        else $error("scan not ascending");

    a_scan_end: assert property (
        @(posedge clock) disable iff (!rstn)
        (s_reg.state == acpc_pkg::ACPC_NORM && conv_done &&
         s_reg.cur_chan == s_reg.last_chan)
        |=> s_reg.state == acpc_pkg::ACPC_IDLE)
        else $error("scan runs past its last input");
endmodule
`default_nettype wire

// >>> test/acpc_top_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "acpc_consts.svh"
module acpc_top_test;
    logic        clock;
    logic        rstn;
    logic [4:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        idle_mode;
    logic        conv_done;
    logic        conv_req;
    logic [3:0]  conv_chan;
    logic        ref_voltage_on;
    logic        conv_enable;
    logic        irq;
    int          err_count;
    int          n_tests;

    acpc_top acpc_top_inst (
        .clock           (clock),
        .rstn            (rstn),
        .avs_address     (avs_address),
        .avs_read        (avs_read),
        .avs_write       (avs_write),
        .avs_writedata   (avs_writedata),
        .avs_readdata    (avs_readdata),
        .avs_waitrequest (avs_waitrequest),
        .idle_mode       (idle_mode),
        .conv_done       (conv_done),
        .conv_req        (conv_req),
        .conv_chan       (conv_chan),
        .ref_voltage_on  (ref_voltage_on),
        .conv_enable     (conv_enable),
        .irq             (irq)
    );

    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    task automatic report_and_stop();
        $display("errors %0d of %0d checks", err_count, n_tests);
        if (err_count == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One Avalon access; the request is held until waitrequest is low.
    task automatic bus(input logic wr, input logic [4:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        int n;
        @(posedge clock);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= ~wr;
        avs_writedata <= d;
        for (n = 0; n < 20; n++) begin
            @(posedge clock);
            if (avs_waitrequest === 1'b0) break;
        end
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (n == 20) begin
            err_count++;
            report_and_stop();
        end
    endtask

    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rchk(input string what, input logic [4:0] a,
                        input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(what, exp, q);
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clock);
    endtask

    // Waits for a conversion request and checks its input.
    task automatic conv_seen(input logic [3:0] exp);
        int n;
        for (n = 0; n < 50; n++) begin
            @(posedge clock);
            if (conv_req === 1'b1) break;
        end
        chk("conv_chan", {28'h0, exp}, {28'h0, conv_chan});
        if (n == 50) begin
            err_count++;
            report_and_stop();
        end
    endtask

    // Ends the running conversion with a one-cycle done pulse.
    task automatic conv_end();
        @(posedge clock);
        conv_done <= 1'b1;
        @(posedge clock);
        conv_done <= 1'b0;
    endtask

    task automatic conv(input logic [3:0] exp);
        conv_seen(exp);
        conv_end();
    endtask

    task automatic scan(input logic wide, input logic [3:0] code);
        logic [3:0] c;
        c = code[3] ? 4'h8 : ((code[2] && !wide) ? 4'h4 : 4'h0);
        wr(5'h04, {24'h0, 1'b1, 1'b0, wide, 1'b0, code});
        wr(5'h00, 32'h3);
        for (; c <= code; c++) conv(c);
        repeat (6) begin
            @(posedge clock);
            chk("extra conv_req", 32'h0, {31'h0, conv_req});
        end
    endtask

    initial begin
        err_count = 0;
        n_tests = 0;
        rstn = 1'b0;
        avs_address = 5'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        idle_mode = 1'b0;
        conv_done = 1'b0;
        repeat (8) @(posedge clock);
        rstn <= 1'b1;
        rchk("chan reset", 5'h04, 32'h0);
        rchk("prio reset", 5'h08, 32'h0);
        rchk("unmapped", 5'h14, 32'h0);
        wr(5'h04, 32'hFFFF_00E5);
        rchk("chan readback", 5'h04, 32'hE5);
        settle(2);
        chk("ref on", 32'h1, {31'h0, ref_voltage_on});
        idle_mode <= 1'b1;
        settle(5);
        chk("idle run", 32'h1, {31'h0, conv_enable});
        wr(5'h04, 32'h25);
        settle(5);
        chk("ref off", 32'h0, {31'h0, ref_voltage_on});
        chk("idle stop", 32'h0, {31'h0, conv_enable});
        idle_mode <= 1'b0;
        settle(5);
        chk("idle left", 32'h1, {31'h0, conv_enable});
        wr(5'h04, 32'hA5);
        settle(`ACPC_REF_SETTLE_CYC);
        wr(5'h08, 32'h25);
        conv_seen(4'h5);
        rchk("prio busy", 5'h08, 32'h45);
        conv_end();
        rchk("prio done", 5'h08, 32'h85);
        rchk("prio cleared", 5'h08, 32'h05);
        wr(5'h08, 32'h05);
        settle(4);
        chk("no start", 32'h0, {31'h0, conv_req});
        rchk("no busy", 5'h08, 32'h05);
        chk("irq masked", 32'h0, {31'h0, irq});
        rchk("irq stat", 5'h0C, 32'h2);
        wr(5'h10, 32'h2);
        settle(2);
        chk("irq on", 32'h1, {31'h0, irq});
        wr(5'h0C, 32'h2);
        settle(2);
        chk("irq clear", 32'h0, {31'h0, irq});
        wr(5'h04, 32'h8B);
        wr(5'h00, 32'h1);
        conv(4'hB);
        rchk("mode0 done", 5'h00, 32'h80);
        scan(1'b0, 4'h6);
        scan(1'b1, 4'h6);
        scan(1'b0, 4'hA);
        scan(1'b0, 4'h2);
        scan(1'b1, 4'hB);
        wr(5'h04, 32'h0);
        settle(2);
        chk("ref standby", 32'h0, {31'h0, ref_voltage_on});
        rstn <= 1'b0;
        repeat (2) @(posedge clock);
        rstn <= 1'b1;
        rchk("mode0 after reset", 5'h00, 32'h0);
        rchk("prio after reset", 5'h08, 32'h0);
        report_and_stop();
    end
endmodule
`default_nettype wire
